// ==== core/icsr_regs.vh ====
`ifndef ICSR_REGS_VH
`define ICSR_REGS_VH
// register word indices (byte address = index * 4)
`define ICSR_IDX_CTRL 4'h0
`define ICSR_IDX_VBASE 4'h1
`define ICSR_IDX_FVL0 4'h2
`define ICSR_IDX_FVH0 4'h3
`define ICSR_IDX_FVL1 4'h4
`define ICSR_IDX_FVH1 4'h5
`define ICSR_IDX_FSEL 4'h6
// control/status field positions
`define ICSR_REQ_BIT 15
`define ICSR_NEST_HI 14
`define ICSR_NEST_LO 13
`define ICSR_VEC_HI 12
`define ICSR_VEC_LO 6
`define ICSR_MASK_BIT 5
`define ICSR_RSVD_ONES 3'h7
`define ICSR_RSVD_ZEROS 2'h0
// reset values
`define ICSR_NEST_RST 2'h0
`define ICSR_VEC_RST 7'h00
`define ICSR_MASK_RST 1'h0
`define ICSR_VBASE_RST 14'h0000
// reset vector hold: edges after reset release
`define ICSR_RST_HOLD_EDGES 2'h2
// priority levels
`define ICSR_LVL_LOWEST 3'h4
`endif

// ==== core/icsr_arbiter.v ====
`timescale 1ns/1ps
`include "icsr_regs.vh"
// picks the highest priority enabled pending source; level 3 beats 0,
// lower index wins a tie. lowest_soft_irq is coded as level 4 (below 0).
module icsr_arbiter #(
  parameter N = 64
) (
  input wire [N-1:0] pend_i,
  input wire [3*N-1:0] lvl_i,
  output reg hit_o,
  output reg [6:0] num_o,
  output reg [2:0] lvl_o
);
  function [2:0] rank;
    input [2:0] l;
    begin
      rank = (l == `ICSR_LVL_LOWEST) ? 3'h0 : l + 3'h1;
    end
  endfunction
  integer i;
  always @* begin
    hit_o = 1'b0;
    num_o = 7'h00;
    lvl_o = 3'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (pend_i[i] && (!hit_o || rank(lvl_i[3*i +: 3]) >= rank(lvl_o))) begin
        hit_o = 1'b1;
        num_o = i[6:0];
        lvl_o = lvl_i[3*i +: 3];
      end
    end
  end
endmodule

// ==== core/icsr_vecgen.v ====
`timescale 1ns/1ps
// vector address former; fast slots bypass the jump table
module icsr_vecgen (
  input wire [13:0] vbase_i,
  input wire [6:0] num_i,
  input wire fast_i,
  input wire [15:0] fast_lo_i,
  input wire [4:0] fast_hi_i,
  output wire [20:0] addr_o
);
  assign addr_o = fast_i ? {fast_hi_i, fast_lo_i} : {vbase_i, num_i};
endmodule

// ==== core/icsr_top.v ====
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - bit 15 shows request driven to core
// - bits 14:13 nesting level needed for nesting
// - bits 12:6 last vector or fast address
// - status fields update only on service entry
// - bit 5 masks all core interrupts
// - bits 4:2 read one, 1:0 zero
// - reset vector on bus during reset
// - reset vector held two edges after release
// - reset disables all but fixed core sources
// - normal vector is base plus number
// - fast vector from 16+5 bit registers
`include "icsr_regs.vh"
module icsr_top #(
  parameter N = 64,
  parameter [6:0] FIXED_FIRST = 7'h01,
  parameter [6:0] FIXED_LAST = 7'h08,
  parameter [20:0] RESET_VECTOR = 21'h000000,
  parameter [N-1:0] FIXED_MAP = {{(N-9){1'b0}}, 9'h1FE},
  parameter [3*N-1:0] FIXED_LVL = {3*N{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:2] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  input wire [N-1:0] irq_src_i,
  input wire [3*N-1:0] irq_lvl_i,
  input wire [N-1:0] irq_en_i,
  input wire core_ack_i,
  input wire [1:0] core_mask_lvl_i,
  output reg core_irq_o,
  output reg [20:0] vector_bus_o,
  output reg core_in_reset_o
);
  reg mask_reg;
  reg [1:0] nest_reg;
  reg [6:0] vec_reg;
  reg [13:0] vbase_reg;
  reg [15:0] fvl0_reg;
  reg [4:0] fvh0_reg;
  reg [15:0] fvl1_reg;
  reg [4:0] fvh1_reg;
  reg [13:0] fsel_reg;
  reg [1:0] hold_reg;
  wire [N-1:0] pend;
  wire hit;
  wire [6:0] num;
  wire [2:0] lvl;
  wire fast0;
  wire fast1;
  wire [20:0] vaddr;
  reg allowed;
  wire bus_req;
  wire wr_en;
  wire [3:0] idx;
  wire [15:0] ctrl_view;

  function [1:0] nest_code;
    input [2:0] l;
    begin
      case (l)
        3'h0: nest_code = 2'h1;
        3'h1: nest_code = 2'h2;
        3'h2: nest_code = 2'h3;
        3'h3: nest_code = 2'h3;
        default: nest_code = 2'h0;
      endcase
    end
  endfunction

  // only fixed core sources survive reset enable; others need irq_en_i
  assign pend = irq_src_i & (FIXED_MAP | irq_en_i);

  icsr_arbiter #(.N(N)) u_arb (
    .pend_i(pend),
    .lvl_i(irq_lvl_i | FIXED_LVL),
    .hit_o(hit),
    .num_o(num),
    .lvl_o(lvl)
  );

  assign fast0 = fsel_reg[13] && (num == {1'b0, fsel_reg[5:0]});
  assign fast1 = fsel_reg[12] && !fast0 && (num == {1'b0, fsel_reg[11:6]});

  icsr_vecgen u_vg (
    .vbase_i(vbase_reg),
    .num_i(num),
    .fast_i(fast0 | fast1),
    .fast_lo_i(fast0 ? fvl0_reg : fvl1_reg),
    .fast_hi_i(fast0 ? fvh0_reg : fvh1_reg),
    .addr_o(vaddr)
  );

  always @* begin
    case (core_mask_lvl_i)
      2'h0: allowed = 1'b1;
      2'h1: allowed = (lvl != 3'h0) && (lvl != `ICSR_LVL_LOWEST);
      2'h2: allowed = (lvl == 3'h2) || (lvl == 3'h3);
      default: allowed = (lvl == 3'h3);
    endcase
  end

  // reset vector sequencing: held during reset and two edges after
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= 2'h0;
      core_in_reset_o <= 1'b1;
    end else begin
      if (hold_reg != `ICSR_RST_HOLD_EDGES) begin
        hold_reg <= hold_reg + 2'h1;
      end
      core_in_reset_o <= (hold_reg + 2'h1) != `ICSR_RST_HOLD_EDGES;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      vector_bus_o <= RESET_VECTOR;
      core_irq_o <= 1'b0;
    end else if ((hold_reg + 2'h1) != `ICSR_RST_HOLD_EDGES && hold_reg != `ICSR_RST_HOLD_EDGES) begin
      vector_bus_o <= RESET_VECTOR;
      core_irq_o <= 1'b0;
    end else begin
      vector_bus_o <= vaddr;
      core_irq_o <= hit && allowed && !mask_reg;
    end
  end

  // status fields captured only when the core enters a service routine;
  // a nested entry overwrites them, software must read early
  always @(posedge clk_i) begin
    if (rst_i) begin
      nest_reg <= `ICSR_NEST_RST;
      vec_reg <= `ICSR_VEC_RST;
    end else if (core_ack_i && core_irq_o) begin
      nest_reg <= nest_code(lvl);
      vec_reg <= vector_bus_o[6:0];
    end
  end

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i;
  assign idx = wb_adr_i;
  assign wb_err_o = 1'b0;

  always @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= `ICSR_MASK_RST;
      vbase_reg <= `ICSR_VBASE_RST;
      fvl0_reg <= 16'h0000;
      fvh0_reg <= 5'h00;
      fvl1_reg <= 16'h0000;
      fvh1_reg <= 5'h00;
      fsel_reg <= 14'h0000;
    end else if (wr_en) begin
      case (idx)
        `ICSR_IDX_CTRL: if (wb_sel_i[0]) mask_reg <= wb_dat_i[`ICSR_MASK_BIT];
        `ICSR_IDX_VBASE: begin
          if (wb_sel_i[0]) vbase_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) vbase_reg[13:8] <= wb_dat_i[13:8];
        end
        `ICSR_IDX_FVL0: begin
          if (wb_sel_i[0]) fvl0_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) fvl0_reg[15:8] <= wb_dat_i[15:8];
        end
        `ICSR_IDX_FVH0: if (wb_sel_i[0]) fvh0_reg <= wb_dat_i[4:0];
        `ICSR_IDX_FVL1: begin
          if (wb_sel_i[0]) fvl1_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) fvl1_reg[15:8] <= wb_dat_i[15:8];
        end
        `ICSR_IDX_FVH1: if (wb_sel_i[0]) fvh1_reg <= wb_dat_i[4:0];
        `ICSR_IDX_FSEL: begin
          if (wb_sel_i[0]) fsel_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) fsel_reg[13:8] <= wb_dat_i[13:8];
        end
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  assign ctrl_view = {core_irq_o, nest_reg, vec_reg, mask_reg,
                      `ICSR_RSVD_ONES, `ICSR_RSVD_ZEROS};

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (idx)
          `ICSR_IDX_CTRL: wb_dat_o <= {16'h0000, ctrl_view};
          `ICSR_IDX_VBASE: wb_dat_o <= {18'h00000, vbase_reg};
          `ICSR_IDX_FVL0: wb_dat_o <= {16'h0000, fvl0_reg};
          `ICSR_IDX_FVH0: wb_dat_o <= {27'h0000000, fvh0_reg};
          `ICSR_IDX_FVL1: wb_dat_o <= {16'h0000, fvl1_reg};
          `ICSR_IDX_FVH1: wb_dat_o <= {27'h0000000, fvh1_reg};
          `ICSR_IDX_FSEL: wb_dat_o <= {18'h00000, fsel_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ==== tb/icsr_top_asserts.sv ====
`timescale 1ns/1ps
module icsr_top_asserts #(parameter [20:0] RESET_VECTOR = 21'h000000) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:2] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire core_irq_o,
  input wire [20:0] vector_bus_o,
  input wire core_in_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rst_vec;
    (vector_bus_o == RESET_VECTOR) [*2];
  endsequence
  sequence s_mask_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h0 && wb_dat_i[5] ##1 wb_ack_o;
  endsequence
  sequence s_ctrl_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
  endsequence
  property p_rst_vec; $fell(rst_i) |-> core_in_reset_o && vector_bus_o == RESET_VECTOR; endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("no reset vector");
  property p_vec_hold; $fell(rst_i) |-> s_rst_vec; endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("reset vector dropped");
  property p_irq_rst; $fell(rst_i) |-> !core_irq_o [*2]; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("request after reset");
  property p_rsvd; s_ctrl_rd |-> wb_dat_o[4:0] == 5'h1C; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper lanes not zero");
  property p_req_bit; s_ctrl_rd |-> wb_dat_o[15] == $past(core_irq_o); endproperty
  a_req_bit: assert property (p_req_bit) else $error("request bit wrong");
  property p_mask; s_mask_wr |=> !core_irq_o [*3]; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
endmodule
bind icsr_top icsr_top_asserts #(.RESET_VECTOR(RESET_VECTOR)) u_icsr_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .core_irq_o(core_irq_o), .vector_bus_o(vector_bus_o), .core_in_reset_o(core_in_reset_o));

// ==== tb/icsr_core_model.sv ====
`timescale 1ns/1ps
module icsr_core_model (
  input wire clk_i,
  input wire rst_i,
  input wire slow_i,
  input wire irq_i,
  output logic ack_o,
  output logic [1:0] lvl_o
);
  logic [1:0] wait_reg;
  assign lvl_o = 2'h0;
  // slow mode lets the request stand four cycles before entry
  always @(posedge clk_i) begin
    if (rst_i || !irq_i) begin
      wait_reg <= 2'h0;
      ack_o <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
      ack_o <= !ack_o && (!slow_i || wait_reg == 2'h3);
    end
  end
endmodule

// ==== tb/icsr_top_tb.sv ====
`timescale 1ns/1ps
module icsr_top_tb;
  localparam logic [20:0] RV = 21'h1F0A5;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [63:0] irq_src_i = 64'h0, irq_en_i = 64'h0;
  logic [191:0] irq_lvl_i = 192'h0;
  logic [1:0] core_mask_lvl_i;
  logic [20:0] vector_bus_o;
  logic wb_ack_o, core_ack_i, core_irq_o, core_in_reset_o, slow = 1'b0;
  int n_mismatch = 0, cmp_count = 0;
  icsr_top #(.RESET_VECTOR(RV)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(),
    .irq_src_i(irq_src_i), .irq_lvl_i(irq_lvl_i), .irq_en_i(irq_en_i), .core_ack_i(core_ack_i),
    .core_mask_lvl_i(core_mask_lvl_i), .core_irq_o(core_irq_o), .vector_bus_o(vector_bus_o),
    .core_in_reset_o(core_in_reset_o));
  icsr_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .irq_i(core_irq_o),
    .ack_o(core_ack_i), .lvl_o(core_mask_lvl_i));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, ex);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
    input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1) n_mismatch++;
    if (wb_ack_o !== 1'b1) print_verdict;
    if (!we) cmp(wb_dat_o, ex);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wt(input bit ack);
    int n;
    n = 0;
    while ((ack ? core_ack_i : core_irq_o) !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 40) n_mismatch++;
    if (n == 40) print_verdict;
  endtask
  // one entry: raise, check vector, let the core enter, drop, read status
  task automatic svc(input int s, input logic [20:0] v, input logic [31:0] c);
    @(posedge clk_i);
    irq_src_i[s] <= 1'b1;
    wt(1'b0);
    cmp({11'h000, vector_bus_o}, {11'h000, v});
    wt(1'b1);
    irq_src_i[s] <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0, c);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    cmp({11'h000, vector_bus_o}, {11'h000, RV});
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0, 32'h0000001C);
    wb(1'b1, 4'h0, 32'h0000FFFF, 32'h0);
    wb(1'b0, 4'h0, 32'h0, 32'h0000003C);
    wb(1'b0, 4'hF, 32'h0, 32'h0);
    irq_en_i[9] <= 1'b1;
    irq_lvl_i[29:27] <= 3'h1;
    irq_src_i[9] <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp({31'h0, core_irq_o}, 32'h0);
    irq_src_i[9] <= 1'b0;
    wb(1'b1, 4'h1, 32'h00000155, 32'h0);
    wb(1'b1, 4'h0, 32'h0, 32'h0);
    svc(9, {14'h0155, 7'h09}, 32'h0000425C);
    slow <= 1'b1;
    svc(1, {14'h0155, 7'h01}, 32'h0000205C);
    irq_lvl_i[29:27] <= 3'h2;
    wb(1'b1, 4'h2, 32'h00001234, 32'h0);
    wb(1'b1, 4'h3, 32'h00000015, 32'h0);
    wb(1'b1, 4'h6, 32'h00002009, 32'h0);
    svc(9, 21'h151234, 32'h00006D1C);
    print_verdict;
  end
endmodule
